// file: rtl/srf_pkg.sv
// package of constants for the serial register port with flash backup
package srf_pkg;
	localparam int unsigned FRAME_BITS = 16;
	localparam int unsigned ADDR_BITS = 7;
	localparam int unsigned NUM_BYTES = 128;
	localparam int unsigned NUM_REGS = 64;
	localparam logic [6:0] CMD_ADDR_LO = 7'h3e;
	localparam logic [6:0] CMD_ADDR_HI = 7'h3f;
	localparam int unsigned CMD_FLASH_BIT = 6;
	localparam int unsigned CMD_RESET_BIT = 7;
	localparam logic [15:0] CMD_FLASH_WORD = 16'hbe40;
	localparam int unsigned WR_BIT = 15;
	localparam logic [63:0] BACKUP_MASK = 64'h0000_0000_0000_f3ff;
	localparam int unsigned CLK_MHZ = 20;
	localparam int unsigned STALL_NS = 15400;
	localparam int unsigned STALL_CYC = (STALL_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] BIT_LAST = 4'hf;
	localparam logic [6:0] IDX_ZERO = 7'h00;
	localparam logic [6:0] IDX_LAST = 7'h7f;
	typedef enum logic [1:0] {
		SRF_LOAD = 2'b00,
		SRF_RUN = 2'b01,
		SRF_STORE = 2'b11
	} srf_mode_t;
endpackage : srf_pkg

// file: rtl/srf_port.sv
// serial register port with sram working copy and flash backup store
//
// Summary of operation
// - active only while chip select low
// - sample input bits on rising clock
// - shift output bits on falling clock
// - drive output only while selected
// - output answers previously received read command
// - sixteen-bit registers, two byte addresses
// - run from sram; backup subset in flash
// - update command copies backup registers flash
// - reset reloads flash into sram first
// - reads take two frames, pipelined
// - one byte written per frame
// - seven-bit byte address in command
module srf_port
	import srf_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	output logic ready,
	output logic flash_busy,
	output logic [15:0] flash_writes
);
	typedef struct packed {
		logic [1:0] cs_s;
		logic [1:0] ck_s;
		logic [1:0] di_s;
		logic ck_prev;
		logic [3:0] bitn;
		logic [15:0] sh_in;
		logic [15:0] sh_out;
		logic [15:0] rdata;
		logic out_bit;
		logic oe;
		srf_mode_t mode;
		logic [6:0] idx;
		logic rdy;
		logic [15:0] fcount;
		logic busy;
	} srf_state_t;

	srf_state_t s_q, s_d;
	logic [7:0] sram [NUM_BYTES];
	logic [7:0] flash [NUM_BYTES];
	logic frame_done;
	logic [6:0] fr_addr;
	logic fr_wr;
	logic [7:0] fr_data;
	logic sram_we;
	logic [6:0] sram_wa;
	logic [7:0] sram_wd;
	logic flash_we;
	logic cs_act;
	logic rise;
	logic fall;
	logic backed;

	// synchronised pin views; logic reads only the second stage
	assign cs_act = ~s_q.cs_s[1];
	assign rise = s_q.ck_s[1] & ~s_q.ck_prev;
	assign fall = ~s_q.ck_s[1] & s_q.ck_prev;
	assign backed = BACKUP_MASK[s_q.idx[6:1]];

	// next-state logic for the serial engine and the memory walker
	always_comb
	begin
		s_d = s_q;
		frame_done = 1'b0;
		fr_addr = s_q.sh_in[14:8];
		fr_wr = s_q.sh_in[WR_BIT];
		fr_data = s_q.sh_in[7:0];
		s_d.cs_s = {s_q.cs_s[0], cs_n};
		s_d.ck_s = {s_q.ck_s[0], sclk};
		s_d.di_s = {s_q.di_s[0], din};
		s_d.ck_prev = s_q.ck_s[1];
		if (!cs_act)
		begin
			s_d.bitn = '0;
			s_d.oe = 1'b0;
		end
		else
		begin
			s_d.oe = 1'b1;
			if (rise)
			begin
				s_d.sh_in = {s_q.sh_in[14:0], s_q.di_s[1]};
				s_d.bitn = s_q.bitn + 4'h1;
				if (s_q.bitn == BIT_LAST)
				begin
					frame_done = 1'b1;
					fr_addr = s_q.sh_in[13:7];
					fr_wr = s_q.sh_in[14];
					fr_data = {s_q.sh_in[6:0], s_q.di_s[1]};
				end
			end
			if (fall)
			begin
				s_d.out_bit = s_q.sh_out[15];
				s_d.sh_out = {s_q.sh_out[14:0], 1'b0};
			end
		end
		if (cs_act && s_q.bitn == 4'h0 && !rise && !fall && s_q.ck_s[1])
		begin
			s_d.sh_out = s_q.rdata;
		end
		// first frame fetches, next frame returns
		if (frame_done && !fr_wr)
		begin
			s_d.rdata = {sram[{fr_addr[6:1], 1'b1}], sram[{fr_addr[6:1], 1'b0}]};
		end
		// memory walker: load at reset, store on command
		case (s_q.mode)
			SRF_LOAD:
			begin
				s_d.idx = s_q.idx + 7'h01;
				if (s_q.idx == IDX_LAST)
				begin
					s_d.mode = SRF_RUN;
					s_d.rdy = 1'b1;
				end
			end
			SRF_RUN:
			begin
				s_d.idx = IDX_ZERO;
				if (frame_done && fr_wr && fr_addr == CMD_ADDR_LO && fr_data[CMD_FLASH_BIT])
				begin
					s_d.mode = SRF_STORE;
					s_d.rdy = 1'b0;
					s_d.busy = 1'b1;
				end
			end
			SRF_STORE:
			begin
				s_d.idx = s_q.idx + 7'h01;
				if (s_q.idx == IDX_LAST)
				begin
					s_d.mode = SRF_RUN;
					s_d.rdy = 1'b1;
					s_d.fcount = s_q.fcount + 16'h0001;
					s_d.busy = 1'b0;
				end
			end
			default:
			begin
				s_d.mode = SRF_LOAD;
				s_d.busy = 1'b0;
			end
		endcase
	end

	// sram and flash write controls
	always_comb
	begin
		sram_we = 1'b0;
		sram_wa = fr_addr;
		sram_wd = fr_data;
		flash_we = 1'b0;
		if (s_q.mode == SRF_LOAD)
		begin
			sram_we = backed;
			sram_wa = s_q.idx;
			sram_wd = flash[s_q.idx];
		end
		else if (frame_done && fr_wr && fr_addr != CMD_ADDR_HI && fr_addr != CMD_ADDR_LO)
		begin
			sram_we = 1'b1;
		end
		if (s_q.mode == SRF_STORE)
		begin
			flash_we = backed;
		end
	end

	// memories hold no reset; flash keeps contents across reset
	always_ff @(posedge mclk)
	begin
		if (sram_we)
			sram[sram_wa] <= sram_wd;
		if (flash_we)
			flash[s_q.idx] <= sram[s_q.idx];
	end

	// state register, synchronous active-low reset
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			s_q <= '{cs_s: 2'b11, ck_s: 2'b11, di_s: 2'b00, ck_prev: 1'b1,
				bitn: 4'h0, sh_in: 16'h0000, sh_out: 16'h0000, rdata: 16'h0000,
				out_bit: 1'b0, oe: 1'b0, mode: SRF_LOAD, idx: IDX_ZERO,
				rdy: 1'b0, fcount: 16'h0000, busy: 1'b0};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign dout = s_q.out_bit;
	assign dout_oe = s_q.oe;
	assign ready = s_q.rdy;
	assign flash_busy = s_q.busy;
	assign flash_writes = s_q.fcount;

	property p_oe_follows_cs;
		@(posedge mclk) disable iff (!rst_n)
		s_q.cs_s[1] |=> !dout_oe;
	endproperty
	a_oe_follows_cs: assert property (p_oe_follows_cs) else $error("dout driven while deselected");

	property p_load_len;
		@(posedge mclk) disable iff (!rst_n)
		$rose(ready) && $past(s_q.mode) == SRF_LOAD |-> $past(s_q.idx) == IDX_LAST;
	endproperty
	a_load_len: assert property (p_load_len) else $error("ready before reload done");

	// flash store ends with count step
	property p_store_count;
		@(posedge mclk) disable iff (!rst_n)
		$fell(flash_busy) |-> flash_writes == $past(flash_writes) + 16'h0001;
	endproperty
	a_store_count: assert property (p_store_count) else $error("flash count not advanced");

	// output changes only after falling edge
	property p_out_on_fall;
		@(posedge mclk) disable iff (!rst_n)
		!$stable(s_q.out_bit) |-> $past(fall);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall) else $error("dout moved off falling edge");

	// bit counter steps only on rising edge
	property p_bit_on_rise;
		@(posedge mclk) disable iff (!rst_n)
		s_q.bitn != $past(s_q.bitn) && s_q.bitn != 4'h0 |-> $past(rise);
	endproperty
	a_bit_on_rise: assert property (p_bit_on_rise) else $error("bit counted off rising edge");

	property p_cs_abort;
		@(posedge mclk) disable iff (!rst_n)
		!cs_act |=> s_q.bitn == 4'h0;
	endproperty
	a_cs_abort: assert property (p_cs_abort) else $error("frame kept after deselect");

	property p_flash_gate;
		@(posedge mclk) disable iff (!rst_n)
		flash_we |-> flash_busy && backed;
	endproperty
	a_flash_gate: assert property (p_flash_gate) else $error("flash written outside store");

	// sram written only at frame end outside load
	property p_one_byte;
		@(posedge mclk) disable iff (!rst_n)
		sram_we && s_q.mode != SRF_LOAD |-> frame_done && fr_wr;
	endproperty
	a_one_byte: assert property (p_one_byte) else $error("sram written mid frame");

	// store walk spans full depth, then ready returns
	sequence s_store_busy;
		flash_busy && !ready;
	endsequence
	sequence s_store_done;
		!flash_busy && ready;
	endsequence
	property p_store_walk;
		@(posedge mclk) disable iff (!rst_n)
		frame_done && fr_wr && fr_addr == CMD_ADDR_LO && fr_data[CMD_FLASH_BIT] && ready
			|=> s_store_busy ##127 s_store_busy ##1 s_store_done;
	endproperty
	a_store_walk: assert property (p_store_walk) else $error("store walk length wrong");
endmodule : srf_port

// file: tb/srf_master.sv
// spi master model that drives mode-3 frames into the port
module srf_master (
	input wire logic mclk,
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 1ns;
	import srf_pkg::*;
	// idle: deselected, clock parked high
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b1;
		din = 1'b0;
	end
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		rx = 16'h0000;
		// full stall gap before every frame
		repeat (STALL_CYC) @(posedge mclk);
		@(posedge mclk) cs_n <= 1'b0;
		repeat (4) @(posedge mclk);
		for (int i = 15; i >= 0; i--)
		begin
			sclk <= 1'b0;
			din <= tx[i];
			repeat (4) @(posedge mclk);
			sclk <= 1'b1;
			rx = {rx[14:0], miso};  // value before this edge lands
			repeat (4) @(posedge mclk);
		end
		cs_n <= 1'b1;
		din <= ~din;  // released line must not look valid
		// short tail so a caller still sees a store that this frame started
		repeat (8) @(posedge mclk);
	endtask : xfer
endmodule : srf_master

// file: tb/srf_port_bench.sv
// self-checking bench for the serial register port
module srf_port_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import srf_pkg::*;
	logic mclk, rst_n, cs_n, sclk, din, dout, dout_oe, ready, flash_busy, miso;
	logic [15:0] flash_writes, v;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	// released output floats, so a read then shows unknown
	assign miso = dout_oe ? dout : 1'bz;
	srf_port dut_u (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
		.dout(dout), .dout_oe(dout_oe), .ready(ready), .flash_busy(flash_busy),
		.flash_writes(flash_writes));
	srf_master m_u (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .din(din), .miso(miso));
	initial
	begin
		mclk = 1'b0;
		rst_n = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// hang guard
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out;
		if (n_mismatch == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		m_u.xfer({1'b1, a, d}, v);
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [15:0] r);
		m_u.xfer({1'b0, a, 8'h00}, r);
		m_u.xfer(16'h0000, r);
	endtask : rd
	task automatic do_reset;
		@(posedge mclk) rst_n <= 1'b0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		for (int i = 0; i < 300 && ready !== 1'b1; i++)
			@(posedge mclk);
		check({15'h0, ready}, 16'h0001);
		check({15'h0, dout_oe}, 16'h0000);
		check(flash_writes, 16'h0000);
	endtask : do_reset
	// byte writes and two pipelined reads
	task automatic t_write_read;
		wr(7'h10, 8'ha5);
		wr(7'h11, 8'h5a);
		rd(7'h11, v);
		check(v, 16'h5aa5);
		wr(7'h10, 8'h3c);
		rd(7'h10, v);
		check(v, 16'h5a3c);
	endtask : t_write_read
	// no update bit, or bit in the wrong byte: no store
	task automatic t_store;
		m_u.xfer(CMD_FLASH_WORD ^ 16'h0040, v);
		m_u.xfer(CMD_FLASH_WORD ^ 16'h0100, v);
		repeat (150) @(posedge mclk);
		check(flash_writes, 16'h0000);
		m_u.xfer(CMD_FLASH_WORD, v);
		check({14'h0, flash_busy, ready}, 16'h0002);
		for (int i = 0; i < 300 && flash_busy !== 1'b0; i++)
			@(posedge mclk);
		check(flash_writes, 16'h0001);
		check({14'h0, flash_busy, ready}, 16'h0001);
	endtask : t_store
	// sram change lost, flash copy restored
	task automatic t_reload;
		wr(7'h10, 8'h00);
		rd(7'h10, v);
		check(v, 16'h5a00);
		do_reset();
		rd(7'h10, v);
		check(v, 16'h5a3c);
	endtask : t_reload
	initial
	begin
		do_reset();
		t_write_read();
		t_store();
		t_reload();
		close_out();
	end
endmodule : srf_port_bench
